// [inc/spectral_autoseq_pkg.sv]
// Constants shared by the spectral read-out sequencer
package spectral_autoseq_pkg;

   // Register offsets (8-bit address space)
   localparam logic [7:0] PERSIST_CFG_ADDR  = 8'hCF;
   localparam logic [7:0] SEQ_CFG_ADDR      = 8'hD6;
   localparam logic [7:0] CONTROL_ADDR      = 8'hE0;
   localparam logic [7:0] INT_STATUS_ADDR   = 8'hE1;
   localparam logic [7:0] INT_MASK_ADDR     = 8'hE2;
   localparam logic [7:0] THR_CHAN_ADDR     = 8'hE3;
   localparam logic [7:0] LOW_THR_L_ADDR    = 8'hE4;
   localparam logic [7:0] LOW_THR_H_ADDR    = 8'hE5;
   localparam logic [7:0] HIGH_THR_L_ADDR   = 8'hE6;
   localparam logic [7:0] HIGH_THR_H_ADDR   = 8'hE7;
   localparam logic [7:0] RESULT_BASE_ADDR  = 8'h95;
   localparam logic [7:0] RESULT_LAST_ADDR  = 8'hB8;

   // Field positions
   localparam int FIFO_BYTE_BIT   = 7;
   localparam int SEQ_MODE_LSB    = 5;
   localparam int PERSIST_CODE_LSB = 0;
   localparam int START_BIT       = 0;

   // Reset values
   localparam logic [7:0] PERSIST_CFG_RESET = 8'h00;
   localparam logic [7:0] SEQ_CFG_RESET   = 8'h00;
   localparam logic [3:0] INT_MASK_RESET  = 4'h0;
   localparam logic [2:0] THR_CHAN_RESET  = 3'h0;
   localparam logic [15:0] LOW_THR_RESET  = 16'h0000;
   localparam logic [15:0] HIGH_THR_RESET = 16'hFFFF;

   // Sequence modes of the read-out field
   localparam logic [1:0] MODE_SINGLE   = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_TWELVE   = 2'h2;
   localparam logic [1:0] MODE_EIGHTEEN = 2'h3;

   // Cycle layout
   localparam int SAMPLES_PER_CYCLE = 6;
   localparam int RESULT_SLOTS      = 18;
   localparam logic [2:0] FLICKER_POS     = 3'h5;
   localparam logic [2:0] LAST_SAMPLE_POS = 3'h5;

   // Filter groups per cycle
   localparam logic [1:0] GROUP_Z_Y_XL_IR = 2'h0;
   localparam logic [1:0] GROUP_F2346     = 2'h1;
   localparam logic [1:0] GROUP_F1578     = 2'h2;

   // Clear photodiode pair: 0 = top-left and bottom-right
   localparam logic CLEAR_PAIR_DEFAULT = 1'b0;

   // Flicker saturation
   localparam logic [15:0] FLICKER_SAT = 16'h00FF;

   // Interrupt status bits
   localparam int EV_CYCLE_DONE = 0;
   localparam int EV_MEAS_DONE  = 1;
   localparam int EV_SPECTRAL   = 2;
   localparam int EV_FLICK_SAT  = 3;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b01,
      ST_CYCLE = 2'b10
   } seq_state_t;

endpackage : spectral_autoseq_pkg

// [verilog/flicker_clamp.sv]
// Flicker value clamp for 8-bit FIFO format
`timescale 1ns/1ps
`default_nettype none
module flicker_clamp
   import spectral_autoseq_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Raw flicker sample
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   input  wire logic        flicker_fifo_byte_mode,
   // Clamped sample
   output logic             out_valid,
   output logic [15:0]      out_data,
   output logic             sat_pulse
);

   logic over_byte;
   assign over_byte = (in_data > FLICKER_SAT);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         out_data  <= 16'h0000;
         sat_pulse <= 1'b0;
      end
      else
      begin
         out_valid <= in_valid;
         sat_pulse <= in_valid && flicker_fifo_byte_mode && over_byte;
         if (in_valid)
         begin
            if (flicker_fifo_byte_mode && over_byte)
               out_data <= FLICKER_SAT;
            else
               out_data <= in_data;
         end
      end
   end

   chk_clamp_saturates: assert property (@(posedge sys_clk) disable iff (!rst_n)
      in_valid && flicker_fifo_byte_mode |=> out_data <= FLICKER_SAT)
      else $error("flicker value above a byte not clamped");

   chk_mode_off_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
      in_valid && !flicker_fifo_byte_mode |=> out_data == $past(in_data))
      else $error("flicker value altered with byte mode off");

endmodule : flicker_clamp
`default_nettype wire

// [verilog/persistence_filter.sv]
// Consecutive out-of-range persistence filter
`timescale 1ns/1ps
`default_nettype none
module persistence_filter
   import spectral_autoseq_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Monitored sample, one per finished cycle
   input  wire logic        sample_valid,
   input  wire logic [15:0] sample,
   input  wire logic [15:0] spectral_low_threshold,
   input  wire logic [15:0] spectral_high_threshold,
   input  wire logic [3:0]  spectral_persistence_count,
   // Interrupt event
   output logic             hit_pulse,
   output logic [5:0]       count
);

   // Samples needed for a given code
   function automatic logic [5:0] required(input logic [3:0] code);
      logic [5:0] c;
      c = {2'b00, code};
      if (code == 4'h0)
         required = 6'h01;
      else if (code <= 4'h3)
         required = c;
      else if (code == 4'h4)
         required = 6'h05;
      else
         required = 6'(5 * (c - 6'h03));
   endfunction : required

   logic outside;
   logic [5:0] count_next;
   assign outside = (sample < spectral_low_threshold) ||
                    (sample > spectral_high_threshold);
   assign count_next = count + 6'h01;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count     <= 6'h00;
         hit_pulse <= 1'b0;
      end
      else
      begin
         hit_pulse <= 1'b0;
         if (sample_valid)
         begin
            if (spectral_persistence_count == 4'h0)
            begin
               hit_pulse <= 1'b1;
               count     <= 6'h00;
            end
            else if (!outside)
               count <= 6'h00;
            else if (count_next >= required(spectral_persistence_count))
            begin
               hit_pulse <= 1'b1;
               count     <= 6'h00;
            end
            else
               count <= count_next;
         end
      end
   end

   chk_inrange_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sample_valid && !outside |=> count == 6'h00)
      else $error("in-range sample did not clear the counter");

   chk_code_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sample_valid && spectral_persistence_count == 4'h0 |=> hit_pulse)
      else $error("code zero did not interrupt on the cycle");

   chk_hit_needs_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sample_valid && outside && spectral_persistence_count != 4'h0 &&
      count_next < required(spectral_persistence_count) |=> !hit_pulse)
      else $error("interrupt before persistence count reached");

endmodule : persistence_filter
`default_nettype wire

// [verilog/spectral_autoseq.sv]
// Spectral automatic read-out sequencer with persistence interrupt
//
// Functional notes
// - Bit 7 enables 8-bit flicker FIFO format
// - Flicker above a byte saturates to FF
// - Mode 0 runs one six-channel cycle
// - Mode 2 runs two cycles, twelve channels
// - Mode 3 runs three cycles, eighteen channels
// - Sequence runs alone, each result own slot
// - Clear pair defaults top-left, bottom-right
// - Persistence code sets consecutive out-of-range samples
// - Only the selected channel is monitored
// - In-range sample clears the counter
// - Persistence code decoding, zero means every cycle
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module spectral_autoseq
   import spectral_autoseq_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Converter front end
   output logic             cycle_req,
   output logic [1:0]       filter_group,
   output logic             clear_pair_sel,
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_data,
   // Flicker FIFO feed
   output logic             flicker_fifo_valid,
   output logic [15:0]      flicker_fifo_data,
   // Status
   output logic             busy,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [1:0] cycles_for(input logic [1:0] mode);
      unique case (mode)
         MODE_TWELVE:   cycles_for = 2'h2;
         MODE_EIGHTEEN: cycles_for = 2'h3;
         default:       cycles_for = 2'h1;
      endcase
   endfunction : cycles_for

   function automatic logic [4:0] slot_of(input logic [1:0] cyc,
                                          input logic [2:0] pos);
      slot_of = 5'(cyc * SAMPLES_PER_CYCLE) + {2'b00, pos};
   endfunction : slot_of

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]  persist_cfg_reg;
   logic [7:0]  seq_cfg_reg;
   logic [3:0]  int_status_reg;
   logic [3:0]  int_mask_reg;
   logic [2:0]  thr_chan_reg;
   logic [15:0] low_thr_reg;
   logic [15:0] high_thr_reg;
   logic [15:0] result_mem [RESULT_SLOTS];

   logic        flicker_fifo_byte_mode;
   logic [1:0]  seq_mode;
   logic [3:0]  spectral_persistence_count;
   assign flicker_fifo_byte_mode     = seq_cfg_reg[FIFO_BYTE_BIT];
   assign seq_mode                   = seq_cfg_reg[SEQ_MODE_LSB +: 2];
   assign spectral_persistence_count = persist_cfg_reg[PERSIST_CODE_LSB +: 4];

   logic wr_control;
   logic start_req;
   assign wr_control = reg_wr && (reg_addr == CONTROL_ADDR);
   assign start_req  = wr_control && reg_wdata[START_BIT];

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         persist_cfg_reg <= PERSIST_CFG_RESET;
         seq_cfg_reg  <= SEQ_CFG_RESET;
         int_mask_reg <= INT_MASK_RESET;
         thr_chan_reg <= THR_CHAN_RESET;
         low_thr_reg  <= LOW_THR_RESET;
         high_thr_reg <= HIGH_THR_RESET;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            PERSIST_CFG_ADDR: persist_cfg_reg <= {4'h0, reg_wdata[3:0]};
            SEQ_CFG_ADDR:    seq_cfg_reg  <= {reg_wdata[7:5], 5'h00};
            INT_MASK_ADDR:   int_mask_reg <= reg_wdata[3:0];
            THR_CHAN_ADDR:   thr_chan_reg <= reg_wdata[2:0];
            LOW_THR_L_ADDR:  low_thr_reg[7:0]   <= reg_wdata;
            LOW_THR_H_ADDR:  low_thr_reg[15:8]  <= reg_wdata;
            HIGH_THR_L_ADDR: high_thr_reg[7:0]  <= reg_wdata;
            HIGH_THR_H_ADDR: high_thr_reg[15:8] <= reg_wdata;
            default:         ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   seq_state_t state_reg;
   logic [1:0] cycle_reg;
   logic [1:0] last_cycle_reg;
   logic [2:0] pos_reg;
   logic       cycle_end;
   logic       meas_done;

   assign cycle_end = (state_reg == ST_CYCLE) && conv_valid &&
                      (pos_reg == LAST_SAMPLE_POS);
   assign meas_done = cycle_end && (cycle_reg == last_cycle_reg);
   assign busy      = (state_reg == ST_CYCLE);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg      <= ST_IDLE;
         cycle_reg      <= 2'h0;
         last_cycle_reg <= 2'h0;
         pos_reg        <= 3'h0;
         cycle_req      <= 1'b0;
      end
      else
      begin
         cycle_req <= 1'b0;
         unique case (state_reg)
            ST_IDLE:
            begin
               if (start_req)
               begin
                  // Mode is sampled here; software keeps it still while busy
                  last_cycle_reg <= cycles_for(seq_mode) - 2'h1;
                  cycle_reg      <= 2'h0;
                  pos_reg        <= 3'h0;
                  cycle_req      <= 1'b1;
                  state_reg      <= ST_CYCLE;
               end
            end
            ST_CYCLE:
            begin
               if (conv_valid)
               begin
                  if (pos_reg != LAST_SAMPLE_POS)
                     pos_reg <= pos_reg + 3'h1;
                  else if (meas_done)
                     state_reg <= ST_IDLE;
                  else
                  begin
                     pos_reg   <= 3'h0;
                     cycle_reg <= cycle_reg + 2'h1;
                     cycle_req <= 1'b1;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Filter group follows the cycle number
   always_comb
   begin
      unique case (cycle_reg)
         2'h1:    filter_group = GROUP_F2346;
         2'h2:    filter_group = GROUP_F1578;
         default: filter_group = GROUP_Z_Y_XL_IR;
      endcase
   end

   assign clear_pair_sel = CLEAR_PAIR_DEFAULT;

   ////////////////////////////////////////////////////////////////////////
   // Result slots

   logic       flick_in;
   logic       flick_sat;
   logic [4:0] flick_slot_reg;
   logic       sample_take;
   assign sample_take = (state_reg == ST_CYCLE) && conv_valid;
   assign flick_in    = sample_take && (pos_reg == FLICKER_POS);

   flicker_clamp u_clamp
   (
      .sys_clk                (sys_clk),
      .rst_n                  (rst_n),
      .in_valid               (flick_in),
      .in_data                (conv_data),
      .flicker_fifo_byte_mode (flicker_fifo_byte_mode),
      .out_valid              (flicker_fifo_valid),
      .out_data               (flicker_fifo_data),
      .sat_pulse              (flick_sat)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         flick_slot_reg <= 5'h00;
      else if (flick_in)
         flick_slot_reg <= slot_of(cycle_reg, pos_reg);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sample_take && !flick_in)
         result_mem[slot_of(cycle_reg, pos_reg)] <= conv_data;
      if (flicker_fifo_valid)
         result_mem[flick_slot_reg] <= flicker_fifo_data;
   end

   ////////////////////////////////////////////////////////////////////////
   // Persistence

   logic [15:0] mon_sample_reg;
   logic [15:0] mon_sample;
   logic        spectral_hit;
   assign mon_sample = (sample_take && pos_reg == thr_chan_reg) ?
                       conv_data : mon_sample_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         mon_sample_reg <= 16'h0000;
      else
         mon_sample_reg <= mon_sample;
   end

   persistence_filter u_persist
   (
      .sys_clk                    (sys_clk),
      .rst_n                      (rst_n),
      .sample_valid               (cycle_end),
      .sample                     (mon_sample),
      .spectral_low_threshold     (low_thr_reg),
      .spectral_high_threshold    (high_thr_reg),
      .spectral_persistence_count (spectral_persistence_count),
      .hit_pulse                  (spectral_hit),
      .count                      ()
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   logic [3:0] events;
   logic [3:0] clear_bits;
   assign events = {flick_sat, spectral_hit, meas_done, cycle_end};
   assign clear_bits = (reg_wr && reg_addr == INT_STATUS_ADDR) ?
                       reg_wdata[3:0] : 4'h0;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         int_status_reg <= 4'h0;
      else
         int_status_reg <= (int_status_reg & ~clear_bits) | events;
   end

   assign irq = |(int_status_reg & int_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // Read port

   logic       result_hit;
   logic [7:0] result_off;
   assign result_hit = (reg_addr >= RESULT_BASE_ADDR) &&
                       (reg_addr <= RESULT_LAST_ADDR);
   assign result_off = reg_addr - RESULT_BASE_ADDR;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (!reg_rd)
         reg_rdata <= 8'h00;
      else if (result_hit)
         reg_rdata <= result_off[0] ? result_mem[result_off[5:1]][15:8]
                                    : result_mem[result_off[5:1]][7:0];
      else
      begin
         unique case (reg_addr)
            PERSIST_CFG_ADDR: reg_rdata <= persist_cfg_reg;
            SEQ_CFG_ADDR:    reg_rdata <= seq_cfg_reg;
            CONTROL_ADDR:    reg_rdata <= {7'h00, busy};
            INT_STATUS_ADDR: reg_rdata <= {4'h0, int_status_reg};
            INT_MASK_ADDR:   reg_rdata <= {4'h0, int_mask_reg};
            THR_CHAN_ADDR:   reg_rdata <= {5'h00, thr_chan_reg};
            LOW_THR_L_ADDR:  reg_rdata <= low_thr_reg[7:0];
            LOW_THR_H_ADDR:  reg_rdata <= low_thr_reg[15:8];
            HIGH_THR_L_ADDR: reg_rdata <= high_thr_reg[7:0];
            HIGH_THR_H_ADDR: reg_rdata <= high_thr_reg[15:8];
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_single_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == ST_IDLE && start_req && seq_mode == MODE_SINGLE
      |=> last_cycle_reg == 2'h0)
      else $error("single mode did not plan one cycle");

   chk_eighteen_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
      meas_done && last_cycle_reg == 2'h2 |-> filter_group == GROUP_F1578)
      else $error("eighteen channel run ended on wrong group");

   chk_twelve_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cycle_req && cycle_reg == 2'h1 |-> filter_group == GROUP_F2346)
      else $error("second cycle used wrong filter group");

   chk_start_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_reg == ST_IDLE && start_req |=> busy && cycle_req)
      else $error("start did not launch the first cycle");

   chk_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
      spectral_hit && int_mask_reg[EV_SPECTRAL] |=> irq)
      else $error("spectral event did not raise the interrupt");

endmodule : spectral_autoseq
`default_nettype wire

// [tb/test_spectral_autoseq.sv]
// Self-checking bench for the spectral read-out sequencer
`timescale 1ns/1ps
`default_nettype none
module test_spectral_autoseq
   import spectral_autoseq_pkg::*;
   ();
   logic        sys_clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        cycle_req;
   logic [1:0]  filter_group;
   logic        clear_pair_sel;
   logic        conv_valid;
   logic [15:0] conv_data;
   logic        flicker_fifo_valid;
   logic [15:0] flicker_fifo_data;
   logic        busy;
   logic        irq;
   int          n_fail;
   int          checks;
   int          pcnt;
   logic [31:0] seed;
   logic [3:0]  exp_st;
   logic [15:0] exp_res [0:17];
   logic [15:0] fq [$];

   spectral_autoseq spectral_autoseq_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_req(cycle_req),
      .filter_group(filter_group), .clear_pair_sel(clear_pair_sel),
      .conv_valid(conv_valid), .conv_data(conv_data),
      .flicker_fifo_valid(flicker_fifo_valid),
      .flicker_fifo_data(flicker_fifo_data), .busy(busy), .irq(irq));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic int persist_req(input int c);
      if (c <= 3)
         return c;
      if (c == 4)
         return 5;
      return 5 * (c - 3);
   endfunction : persist_req

   task automatic wrap_up();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic timed_out();
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up();
   endtask : timed_out

   task automatic check_bit(input logic got, input logic e);
      checks++;
      if (got !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: flag %b want %b", $time, got, e);
      end
   endtask : check_bit

   task automatic check_fifo(input logic [15:0] got, input logic [15:0] e);
      checks++;
      if (got !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: fifo %h want %h", $time, got, e);
      end
   endtask : check_fifo

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr_reg

   task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      // Read data stand only in the cycle after the strobe
      @(negedge sys_clk);
      d = reg_rdata;
      checks++;
      if (d !== e)
      begin
         n_fail++;
         $display("unexpected at %0t: reg %h read %h want %h", $time, a, d, e);
      end
   endtask : check_reg

   // Flicker words leave one cycle after the last sample of a cycle
   always @(posedge sys_clk)
   begin
      if (flicker_fifo_valid === 1'b1)
      begin
         if (fq.size() == 0)
            check_fifo(flicker_fifo_data, 16'hXXXX);
         else
            check_fifo(flicker_fifo_data, fq.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One measurement; outs bit c marks cycle c's watched sample out of range
   task automatic measure(input int mode, input int code, input int outs,
                          input logic byte_mode, input int thr);
      int          c;
      int          p;
      int          n;
      int          i;
      logic [31:0] r;
      logic [15:0] v;
      logic [15:0] e;
      logic [3:0]  m;
      n = (mode >= 2) ? mode : 1;
      r = rnd();
      m = r[3:0];
      wr_reg(SEQ_CFG_ADDR, {byte_mode, mode[1:0], 5'h00});
      wr_reg(PERSIST_CFG_ADDR, {4'h0, code[3:0]});
      wr_reg(THR_CHAN_ADDR, thr[7:0]);
      wr_reg(INT_MASK_ADDR, {4'h0, m});
      wr_reg(CONTROL_ADDR, 8'h01);
      for (c = 0; c < n; c++)
      begin
         for (i = 0; i < 50 && cycle_req !== 1'b1; i++)
            @(posedge sys_clk);
         if (i == 50)
            timed_out();
         check_bit(busy, 1'b1);
         check_bit(filter_group === c[1:0], 1'b1);
         check_bit(clear_pair_sel, CLEAR_PAIR_DEFAULT);
         for (p = 0; p < SAMPLES_PER_CYCLE; p++)
         begin
            r = rnd();
            v = r[15:0];
            if (p == thr)
               v = outs[c] ? (r[16] ? 16'h0800 : 16'h3000) : 16'h1800;
            e = v;
            if (p == 5 && byte_mode && v > 16'h00FF)
            begin
               e = FLICKER_SAT;
               exp_st[EV_FLICK_SAT] = 1'b1;
            end
            exp_res[c * 6 + p] = e;
            if (p == 5)
               fq.push_back(e);
            @(posedge sys_clk);
            conv_valid <= 1'b1;
            conv_data  <= v;
         end
         @(posedge sys_clk);
         conv_valid <= 1'b0;
         exp_st[EV_CYCLE_DONE] = 1'b1;
         pcnt = outs[c] ? pcnt + 1 : 0;
         if (code == 0 || pcnt >= persist_req(code))
         begin
            exp_st[EV_SPECTRAL] = 1'b1;
            pcnt = 0;
         end
      end
      for (i = 0; i < 50 && busy !== 1'b0; i++)
         @(posedge sys_clk);
      if (i == 50)
         timed_out();
      exp_st[EV_MEAS_DONE] = 1'b1;
      @(posedge sys_clk);
      check_bit(irq, |(exp_st & m));
      check_reg(INT_STATUS_ADDR, {4'h0, exp_st});
      for (i = 0; i < n * 6; i++)
      begin
         check_reg(RESULT_BASE_ADDR + 8'(2 * i), exp_res[i][7:0]);
         check_reg(RESULT_BASE_ADDR + 8'(2 * i + 1), exp_res[i][15:8]);
      end
      wr_reg(INT_STATUS_ADDR, 8'h0F);
      exp_st = 4'h0;
      check_reg(INT_STATUS_ADDR, 8'h00);
      check_bit(irq, 1'b0);
   endtask : measure

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      int code;
      int k;
      int j;
      seed = 32'h00013CD7;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_valid = 1'b0;
      conv_data = 16'h0000;
      n_fail = 0;
      checks = 0;
      pcnt = 0;
      exp_st = 4'h0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      check_reg(PERSIST_CFG_ADDR, PERSIST_CFG_RESET);
      check_reg(SEQ_CFG_ADDR, SEQ_CFG_RESET);
      check_reg(8'h00, 8'h00);
      wr_reg(LOW_THR_L_ADDR, 8'h00);
      wr_reg(LOW_THR_H_ADDR, 8'h10);
      wr_reg(HIGH_THR_L_ADDR, 8'h00);
      wr_reg(HIGH_THR_H_ADDR, 8'h20);
      for (code = 0; code < 16; code++)
      begin
         // In-range sample first, so both counters start at zero
         measure(code % 2, code, 0, code[0], code % 5);
         k = persist_req(code) / (1 + code % 2) + 1;
         for (j = 0; j < k; j++)
            measure(2 + code % 2, code, 7, code[1], code % 5);
      end
      measure(3, 3, 3, 1'b1, 2);
      measure(3, 3, 7, 1'b0, 2);
      repeat (4) @(posedge sys_clk);
      check_bit(fq.size() == 0, 1'b1);
      wrap_up();
   end
endmodule : test_spectral_autoseq
`default_nettype wire
